//--- rtl/flash_mode_map.vh
`ifndef FLASH_MODE_MAP_VH
`define FLASH_MODE_MAP_VH

// ============================================================
// Clock and operation times.
`define CLK_KHZ 50000
`define T_SECT_ERASE_MS 5
`define T_SECT_PROG_MS 40
`define T_SEC_SET_MS 400
`define T_CHIP_ERASE_MS 10
`define T_POR_INHIBIT_MS 12

// ============================================================
// Sector geometry and RAM staging window.
`define SECT_BYTES 128
`define SECT_IDX_W 7
`define SECT_NUM_W 10
`define RAM_ADDR_W 11
`define RAM_WIN_BASE 11'h300

// ============================================================
// Modes, one-hot.
`define MODE_NORMAL 4'h1
`define MODE_USER 4'h2
`define MODE_SERIAL 4'h4
`define MODE_PARALLEL 4'h8

// ============================================================
// External programmer commands.
`define CMD_READ 2'h0
`define CMD_LOAD 2'h1
`define CMD_PROG 2'h2
`define CMD_SECURE 2'h3

// ============================================================
// Register word indices on the bus and field positions.
`define REG_CTRL 2'h0
`define REG_SECT 2'h1
`define REG_STATUS 2'h2
`define CTRL_PROG_BIT 0
`define CTRL_CHIP_BIT 1
`define CTRL_SECSET_BIT 2
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_REFUSED_BIT 2
`define ST_SECURE_BIT 3
`define ST_INHIBIT_BIT 4
`define ALL_ONES_32 32'hffffffff

`endif

//--- rtl/flash_program_mode_control.v
`include "flash_mode_map.vh"
`default_nettype none

module flash_program_mode_control #(
  parameter integer CLK_KHZ = `CLK_KHZ,
  parameter integer SECT_ERASE_CYC = `T_SECT_ERASE_MS * `CLK_KHZ,
  parameter integer SECT_PROG_CYC = `T_SECT_PROG_MS * `CLK_KHZ,
  parameter integer SEC_SET_CYC = `T_SEC_SET_MS * `CLK_KHZ,
  parameter integer CHIP_ERASE_CYC = `T_CHIP_ERASE_MS * `CLK_KHZ,
  parameter integer POR_CYC = `T_POR_INHIBIT_MS * `CLK_KHZ
) (
  // Clock and block reset.
  input wire ref_clk,
  input wire srst,
  // Power and mode pins.
  input wire por,
  input wire supply_low,
  input wire res_active,
  input wire stop_mode,
  input wire external_access_pin,
  input wire test_pin,
  input wire parallel_sel,
  // Classic Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // External programmer port.
  input wire ext_req,
  input wire [1:0] ext_cmd,
  input wire [16:0] ext_addr,
  input wire ext_control_program_store,
  input wire [7:0] ext_wdata,
  output reg ext_ack,
  output reg ext_err,
  output reg [7:0] ext_rdata,
  output wire ext_busy,
  // Fetch steering.
  output wire control_program_store_fetch_en,
  output wire [3:0] mode,
  // Staging RAM read port, one cycle latency.
  output reg [`RAM_ADDR_W-1:0] ram_addr,
  input wire [7:0] ram_rdata,
  // Flash macro.
  output reg flash_rd,
  output reg [16:0] flash_addr,
  output reg flash_control_program_store,
  input wire [7:0] flash_rdata,
  output reg flash_pg_wr,
  output reg [`SECT_IDX_W-1:0] flash_pg_idx,
  output reg [7:0] flash_pg_data,
  output reg flash_erase,
  output reg flash_chip_erase,
  output reg flash_prog,
  input wire sec_nv,
  output reg sec_set,
  output reg sec_clr
);

  // ============================================================
  // Engine states.
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_COPY = 5'h02;
  localparam [4:0] S_ERASE = 5'h04;
  localparam [4:0] S_PROG = 5'h08;
  localparam [4:0] S_LONG = 5'h10;

  // The phase counters run down to zero inclusive, so they start one below the cycle budget.
  function [24:0] cyc25;
    input integer n;
    begin
      cyc25 = n[24:0] - 25'h0000001;
    end
  endfunction

  reg [3:0] mode_r;
  reg res_d_r;
  reg [23:0] por_cnt_r;
  reg [4:0] st_r;
  reg [4:0] st_nxt;
  reg [24:0] cnt_r;
  reg [7:0] idx_r;
  reg cp_valid_r;
  reg [`SECT_IDX_W-1:0] cp_idx_r;
  reg from_user_r;
  reg long_kind_r;
  reg [`SECT_NUM_W-1:0] sect_r;
  reg done_r;
  reg refused_r;
  reg rd_pend_r;

  wire secure = sec_nv;
  wire user = (mode_r == `MODE_USER);
  wire inhibit = (por_cnt_r != 24'h000000) | supply_low;
  wire busy = (st_r != S_IDLE);
  wire serial_ok = ((mode_r == `MODE_SERIAL) & res_active) | ((mode_r == `MODE_NORMAL) & stop_mode);
  wire ext_mode_ok = (mode_r == `MODE_PARALLEL) | serial_ok;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land at the edge on which the master samples ack high.
  wire wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & user;
  wire [1:0] wb_idx = wb_adr_i[3:2];
  wire ctrl_wr = wb_wr & (wb_idx == `REG_CTRL) & wb_sel_i[0];
  wire user_prog = ctrl_wr & wb_dat_i[`CTRL_PROG_BIT];
  wire user_chip = ctrl_wr & wb_dat_i[`CTRL_CHIP_BIT];
  wire user_sec = ctrl_wr & wb_dat_i[`CTRL_SECSET_BIT];
  wire user_any = user_prog | user_chip | user_sec;
  wire user_go = user_any & ~busy & ~inhibit;
  wire ext_take = ext_req & ~ext_ack & ~rd_pend_r;
  wire ext_prog = ext_take & (ext_cmd == `CMD_PROG);
  wire ext_load = ext_take & (ext_cmd == `CMD_LOAD);
  wire ext_secure = ext_take & (ext_cmd == `CMD_SECURE);
  wire ext_read = ext_take & (ext_cmd == `CMD_READ);
  wire ext_ok_base = ext_mode_ok & ~busy;
  wire ext_prog_ok = ext_ok_base & ~secure & ~inhibit;
  wire ext_sec_ok = ext_ok_base & ~inhibit & serial_ok;
  wire ext_go_prog = ext_prog & ext_prog_ok & ~user_go;
  wire ext_go_sec = ext_secure & ext_sec_ok & ext_wdata[0] & ~user_go;
  // A security clear from the programmer is a short pulse with no wait; parallel mode never reaches it.
  wire sec_clr_ext = ext_secure & ext_sec_ok & ~ext_wdata[0];
  wire op_end = busy & (st_r != S_COPY) & (cnt_r == 25'h0000000);
  wire [31:0] status_word = {27'h0000000, inhibit, secure, refused_r, done_r, busy};

  assign ext_busy = busy;
  assign mode = mode_r;
  assign control_program_store_fetch_en = user;

  // ============================================================
  // Mode latch on reset release and power-on inhibit.
  always @(posedge ref_clk) begin
    if (srst) begin
      res_d_r <= 1'b1;
      mode_r <= `MODE_NORMAL;
    end else begin
      res_d_r <= res_active;
      if (res_d_r & ~res_active) begin
        // Sampled once here and frozen, so pin noise later cannot move the fetch source.
        if (external_access_pin & test_pin) begin
          mode_r <= `MODE_USER;
        end else if (parallel_sel) begin
          mode_r <= `MODE_PARALLEL;
        end else begin
          mode_r <= `MODE_NORMAL;
        end
      end else if (res_active & ~test_pin & ~parallel_sel) begin
        mode_r <= `MODE_SERIAL;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (por) begin
      por_cnt_r <= POR_CYC[23:0];
    end else if (por_cnt_r != 24'h000000) begin
      por_cnt_r <= por_cnt_r - 24'h000001;
    end
  end

  // ============================================================
  // Operation engine.
  always @* begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: begin
        if (user_go & user_prog) begin
          st_nxt = S_COPY;
        end else if (user_go) begin
          st_nxt = S_LONG;
        end else if (ext_go_prog) begin
          st_nxt = S_ERASE;
        end else if (ext_go_sec) begin
          st_nxt = S_LONG;
        end
      end
      S_COPY: begin
        if (idx_r == `SECT_BYTES) begin
          st_nxt = S_ERASE;
        end
      end
      S_ERASE: begin
        if (cnt_r == 25'h0000000) begin
          st_nxt = S_PROG;
        end
      end
      S_PROG: begin
        if (cnt_r == 25'h0000000) begin
          st_nxt = S_IDLE;
        end
      end
      S_LONG: begin
        if (cnt_r == 25'h0000000) begin
          st_nxt = S_IDLE;
        end
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      st_r <= S_IDLE;
      cnt_r <= 25'h0000000;
      idx_r <= 8'h00;
      from_user_r <= 1'b0;
      long_kind_r <= 1'b0;
      flash_erase <= 1'b0;
      flash_chip_erase <= 1'b0;
      flash_prog <= 1'b0;
      sec_set <= 1'b0;
      sec_clr <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sec_set <= 1'b0;
      sec_clr <= 1'b0;
      if (busy & (cnt_r != 25'h0000000)) begin
        cnt_r <= cnt_r - 25'h0000001;
      end
      case (st_r)
        S_IDLE: begin
          idx_r <= 8'h00;
          sec_clr <= sec_clr_ext;
          if (st_nxt == S_COPY) begin
            from_user_r <= 1'b1;
          end else if (st_nxt == S_ERASE) begin
            from_user_r <= 1'b0;
            cnt_r <= cyc25(SECT_ERASE_CYC);
            flash_erase <= 1'b1;
          end else if ((st_nxt == S_LONG) & user_chip) begin
            long_kind_r <= 1'b1;
            flash_chip_erase <= 1'b1;
            // The security bit rides on the same erase and costs the extra 400 ms.
            cnt_r <= secure ? cyc25(CHIP_ERASE_CYC + SEC_SET_CYC) : cyc25(CHIP_ERASE_CYC);
          end else if (st_nxt == S_LONG) begin
            long_kind_r <= 1'b0;
            cnt_r <= cyc25(SEC_SET_CYC);
          end
        end
        S_COPY: begin
          idx_r <= idx_r + 8'h01;
          if (st_nxt == S_ERASE) begin
            cnt_r <= cyc25(SECT_ERASE_CYC);
            flash_erase <= 1'b1;
          end
        end
        S_ERASE: begin
          if (st_nxt == S_PROG) begin
            flash_erase <= 1'b0;
            flash_prog <= 1'b1;
            cnt_r <= cyc25(SECT_PROG_CYC);
          end
        end
        S_PROG: begin
          if (st_nxt == S_IDLE) begin
            flash_prog <= 1'b0;
          end
        end
        S_LONG: begin
          if (st_nxt == S_IDLE) begin
            flash_chip_erase <= 1'b0;
            sec_clr <= long_kind_r;
            sec_set <= ~long_kind_r;
          end
        end
        default: begin
          idx_r <= 8'h00;
        end
      endcase
    end
  end

  // ============================================================
  // Page latch writes from RAM window or from the programmer.
  always @(posedge ref_clk) begin
    if (srst) begin
      ram_addr <= `RAM_WIN_BASE;
      cp_valid_r <= 1'b0;
      cp_idx_r <= {`SECT_IDX_W{1'b0}};
      flash_pg_wr <= 1'b0;
      flash_pg_idx <= {`SECT_IDX_W{1'b0}};
      flash_pg_data <= 8'h00;
    end else begin
      ram_addr <= `RAM_WIN_BASE + {4'h0, idx_r[`SECT_IDX_W-1:0]};
      cp_valid_r <= (st_r == S_COPY) & (idx_r != `SECT_BYTES);
      cp_idx_r <= idx_r[`SECT_IDX_W-1:0];
      if (cp_valid_r) begin
        flash_pg_wr <= 1'b1;
        flash_pg_idx <= cp_idx_r;
        flash_pg_data <= ram_rdata;
      end else if (ext_load & ext_prog_ok) begin
        flash_pg_wr <= 1'b1;
        flash_pg_idx <= ext_addr[`SECT_IDX_W-1:0];
        flash_pg_data <= ext_wdata;
      end else begin
        flash_pg_wr <= 1'b0;
      end
    end
  end

  // ============================================================
  // Flash address, programmer answers and read masking.
  always @(posedge ref_clk) begin
    if (srst) begin
      flash_rd <= 1'b0;
      flash_addr <= 17'h00000;
      flash_control_program_store <= 1'b0;
      rd_pend_r <= 1'b0;
      ext_ack <= 1'b0;
      ext_err <= 1'b0;
      ext_rdata <= 8'h00;
    end else begin
      flash_rd <= 1'b0;
      ext_ack <= 1'b0;
      ext_err <= 1'b0;
      if (user_go & user_prog) begin
        flash_addr <= {sect_r, {`SECT_IDX_W{1'b0}}};
        flash_control_program_store <= 1'b0;
      end else if (ext_take & ~busy) begin
        flash_addr <= ext_addr;
        flash_control_program_store <= ext_control_program_store;
      end
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        ext_ack <= 1'b1;
        ext_rdata <= secure ? 8'h00 : flash_rdata;
      end else if (ext_read & ext_ok_base) begin
        flash_rd <= 1'b1;
        rd_pend_r <= 1'b1;
      end else if (ext_take) begin
        ext_ack <= 1'b1;
        ext_err <= ~((ext_read & ext_ok_base) | ((ext_load | ext_prog) & ext_prog_ok & ~(ext_prog & user_go))
                   | (ext_secure & ext_sec_ok & ~(ext_wdata[0] & user_go)));
      end
    end
  end

  // ============================================================
  // Sector register and sticky status flags.
  always @(posedge ref_clk) begin
    if (srst) begin
      sect_r <= {`SECT_NUM_W{1'b0}};
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (wb_wr & (wb_idx == `REG_SECT) & wb_sel_i[0] & wb_sel_i[1]) begin
        sect_r <= wb_dat_i[`SECT_NUM_W-1:0];
      end
      if (op_end & (cnt_r == 25'h0000000) & (st_nxt == S_IDLE)) begin
        done_r <= 1'b1;
      end else if (wb_wr & (wb_idx == `REG_STATUS) & wb_sel_i[0] & wb_dat_i[`ST_DONE_BIT]) begin
        done_r <= 1'b0;
      end
      if (user_any & ~user_go) begin
        refused_r <= 1'b1;
      end else if (wb_wr & (wb_idx == `REG_STATUS) & wb_sel_i[0] & wb_dat_i[`ST_REFUSED_BIT]) begin
        refused_r <= 1'b0;
      end
    end
  end

  // ============================================================
  // Wishbone answer, one wait cycle; outside user mode reads are all ones.
  always @(posedge ref_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req & ~user) begin
        wb_dat_o <= `ALL_ONES_32;
      end else if (wb_req) begin
        case (wb_idx)
          `REG_SECT: wb_dat_o <= {22'h000000, sect_r};
          `REG_STATUS: wb_dat_o <= status_word;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- bench/fpmc_chk_asserts.sv
`include "flash_mode_map.vh"
`default_nettype none
// ============================================================
// Checker on the top-level ports.
module fpmc_chk #(
  parameter integer SECT_PROG_CYC = 40
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Pins.
  input wire logic res_active,
  input wire logic supply_low,
  // Bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Programmer port and flash.
  input wire logic ext_ack,
  input wire logic [7:0] ext_rdata,
  input wire logic control_program_store_fetch_en,
  input wire logic [3:0] mode,
  input wire logic flash_rd,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic flash_chip_erase,
  input wire logic sec_nv,
  input wire logic sec_set,
  input wire logic sec_clr
);
  logic [31:0] prog_cnt_r;
  always_ff @(posedge ref_clk) begin
    prog_cnt_r <= (srst || !flash_prog) ? 32'h0 : prog_cnt_r + 32'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_bus_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack not one cycle after request");
  chk_bus_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  chk_secure_read_zero: assert property (flash_rd && sec_nv |=> ext_ack && ext_rdata == 8'h00)
    else $error("secured read returned data");
  chk_secure_no_erase: assert property ($rose(flash_erase) && !control_program_store_fetch_en |-> !sec_nv)
    else $error("external program while secured");
  chk_parallel_no_sec: assert property (mode == `MODE_PARALLEL |-> !sec_set && !sec_clr)
    else $error("security bit changed in parallel mode");
  chk_erase_first: assert property ($rose(flash_prog) |-> $past(flash_erase) || $past(flash_erase, 2))
    else $error("program without erase");
  chk_prog_time: assert property (flash_prog |-> prog_cnt_r < SECT_PROG_CYC)
    else $error("program phase too long");
  chk_chip_user: assert property (flash_chip_erase |-> control_program_store_fetch_en)
    else $error("chip erase outside user mode");
  chk_low_supply: assert property ($rose(flash_erase) |-> !supply_low && !$past(supply_low))
    else $error("program started at low supply");
  chk_fetch_user: assert property (control_program_store_fetch_en == (mode == `MODE_USER))
    else $error("control store fetch outside user mode");
  chk_mode_hold: assert property (!res_active [*3] |-> $stable(mode))
    else $error("mode changed without reset");
endmodule

bind flash_program_mode_control fpmc_chk #(.SECT_PROG_CYC(SECT_PROG_CYC)) fpmc_chk_inst (.ref_clk, .srst,
  .res_active, .supply_low, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ext_ack, .ext_rdata, .control_program_store_fetch_en, .mode,
  .flash_rd, .flash_erase, .flash_prog, .flash_chip_erase, .sec_nv, .sec_set, .sec_clr);
`default_nettype wire

//--- bench/flash_array_model.sv
`default_nettype none
// ============================================================
// Flash macro, staging RAM and stored security bit.
module flash_array_model (
  // Clock.
  input wire logic ref_clk,
  // Flash macro.
  input wire logic flash_rd,
  input wire logic [16:0] flash_addr,
  input wire logic flash_control_program_store,
  output logic [7:0] flash_rdata,
  input wire logic flash_pg_wr,
  input wire logic [6:0] flash_pg_idx,
  input wire logic [7:0] flash_pg_data,
  input wire logic flash_prog,
  output logic sec_nv,
  input wire logic sec_set,
  input wire logic sec_clr,
  // Staging RAM.
  input wire logic [10:0] ram_addr,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [0:262143];
  logic [7:0] page [0:127];
  logic prog_d;
  initial begin
    sec_nv = 1'b0;
    prog_d = 1'b0;
  end
  // Both arrays read straight from the registered address, as the block samples them one cycle later.
  // Between reads the flash data lines show the inverse, so a flash byte sampled at the wrong time cannot pass.
  assign flash_rdata = flash_rd ? mem[{flash_control_program_store, flash_addr}] : ~mem[{flash_control_program_store, flash_addr}];
  assign ram_rdata = ram_addr[7:0] ^ 8'h5a;
  always @(posedge ref_clk) begin
    prog_d <= flash_prog;
    if (flash_pg_wr) page[flash_pg_idx] <= flash_pg_data;
    if (prog_d && !flash_prog) begin
      for (int i = 0; i < 128; i++) mem[{flash_control_program_store, flash_addr[16:7], i[6:0]}] <= page[i];
    end
    if (sec_set) sec_nv <= 1'b1;
    if (sec_clr) sec_nv <= 1'b0;
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
`include "flash_mode_map.vh"
`default_nettype none
// ============================================================
// Bench top.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, srst = 1'b1, por = 1'b1, supply_low = 1'b0, res_active = 1'b1, stop_mode = 1'b0;
  logic ea = 1'b0, test_pin = 1'b0, parallel_sel = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic ext_req = 1'b0, ext_control_program_store = 1'b0, wb_ack_o, ext_ack, ext_err, ext_busy, control_program_store_fetch_en, sec_nv;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf, mode;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [1:0] ext_cmd = 2'h0;
  logic [16:0] ext_addr = 17'h0, flash_addr;
  logic [7:0] ext_wdata = 8'h0, ext_rdata, ram_rdata, flash_rdata, flash_pg_data;
  logic [10:0] ram_addr;
  logic [6:0] flash_pg_idx;
  logic flash_rd, flash_control_program_store, flash_pg_wr, flash_erase, flash_chip_erase, flash_prog, sec_set, sec_clr;
  int n_fail = 0;
  int tests_run = 0;
  always #10 ref_clk = ~ref_clk;
  flash_program_mode_control #(.SECT_ERASE_CYC(20), .SECT_PROG_CYC(40), .SEC_SET_CYC(50),
    .CHIP_ERASE_CYC(30), .POR_CYC(40)) flash_program_mode_control_inst (.ref_clk, .srst, .por, .supply_low,
    .res_active, .stop_mode, .external_access_pin(ea), .test_pin, .parallel_sel, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_req, .ext_cmd, .ext_addr,
    .ext_control_program_store, .ext_wdata, .ext_ack, .ext_err, .ext_rdata, .ext_busy, .control_program_store_fetch_en, .mode, .ram_addr,
    .ram_rdata, .flash_rd, .flash_addr, .flash_control_program_store, .flash_rdata, .flash_pg_wr, .flash_pg_idx,
    .flash_pg_data, .flash_erase, .flash_chip_erase, .flash_prog, .sec_nv, .sec_set, .sec_clr);
  flash_array_model flash_array_model_inst (.ref_clk, .flash_rd, .flash_addr, .flash_control_program_store, .flash_rdata,
    .flash_pg_wr, .flash_pg_idx, .flash_pg_data, .flash_prog, .sec_nv, .sec_set, .sec_clr, .ram_addr,
    .ram_rdata);
  // ============================================================
  // Tasks.
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Requests are held until the edge that samples ack high, answered there and released right after it.
  // Only the watchdog ends a wait for an answer.
  task automatic ext(input logic [1:0] c, input logic [16:0] a, input logic [7:0] d, output logic e,
    output logic [7:0] q);
    ext_req <= 1'b1;
    ext_cmd <= c;
    ext_addr <= a;
    ext_wdata <= d;
    do @(posedge ref_clk); while (ext_ack !== 1'b1);
    e = ext_err;
    q = ext_rdata;
    ext_req <= 1'b0;
    tick(2);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    tick(1);
  endtask
  task automatic wait_idle();
    tick(3);
    while (ext_busy !== 1'b0) tick(1);
    tick(2);
  endtask
  task automatic set_mode(input logic e, input logic t, input logic p, input logic rel);
    ea <= e;
    test_pin <= t;
    parallel_sel <= p;
    tick(6);
    res_active <= 1'b1;
    tick(6);
    res_active <= !rel;
    tick(6);
  endtask
  // ============================================================
  // Main sequence.
  initial begin
    logic e;
    logic [7:0] q;
    logic [7:0] pg [0:127];
    logic [31:0] r;
    logic [9:0] sect;
    void'($urandom(52005));
    tick(12);
    srst <= 1'b0;
    por <= 1'b0;
    set_mode(1'b0, 1'b0, 1'b1, 1'b1);
    chk("mode", mode, `MODE_PARALLEL);
    chk("fetch", control_program_store_fetch_en, 0);
    ext(`CMD_PROG, 17'h0, 8'h0, e, q);
    chk("por_err", e, 1);
    tick(40);
    supply_low <= 1'b1;
    ext(`CMD_PROG, 17'h0, 8'h0, e, q);
    chk("low_err", e, 1);
    supply_low <= 1'b0;
    ext_control_program_store <= 1'b1;
    sect = {5'h0, 5'($urandom)};
    for (int i = 0; i < 128; i++) begin
      pg[i] = 8'($urandom);
      ext(`CMD_LOAD, 17'(i), pg[i], e, q);
    end
    ext(`CMD_PROG, {sect, 7'h0}, 8'h0, e, q);
    chk("prog_err", e, 0);
    wait_idle();
    for (int i = 0; i < 128; i++) chk("control_program_store", flash_array_model_inst.mem[{1'b1, sect, i[6:0]}], pg[i]);
    ext(`CMD_READ, {sect, 7'h05}, 8'h0, e, q);
    chk("read", q, pg[5]);
    ext(`CMD_SECURE, 17'h0, 8'h1, e, q);
    chk("par_sec_err", e, 1);
    chk("par_sec", sec_nv, 0);
    ea <= 1'b0;
    parallel_sel <= 1'b0;
    res_active <= 1'b1;
    tick(6);
    chk("serial", mode, `MODE_SERIAL);
    ext(`CMD_SECURE, 17'h0, 8'h1, e, q);
    wait_idle();
    chk("sec_set", sec_nv, 1);
    ext(`CMD_READ, {sect, 7'h05}, 8'h0, e, q);
    chk("control_program_store_zero", q, 0);
    ext_control_program_store <= 1'b0;
    ext(`CMD_READ, 17'($urandom), 8'h0, e, q);
    chk("main_zero", q, 0);
    ext(`CMD_LOAD, 17'h0, 8'h0, e, q);
    chk("load_err", e, 1);
    ext(`CMD_PROG, 17'h0, 8'h0, e, q);
    chk("prog_sec_err", e, 1);
    res_active <= 1'b0;
    tick(6);
    ext(`CMD_READ, 17'h0, 8'h0, e, q);
    chk("run_err", e, 1);
    stop_mode <= 1'b1;
    ext(`CMD_READ, 17'h0, 8'h0, e, q);
    chk("stop_err", e, 0);
    chk("stop_zero", q, 0);
    stop_mode <= 1'b0;
    set_mode(1'b1, 1'b1, 1'b0, 1'b1);
    chk("user", mode, `MODE_USER);
    chk("fetch_u", control_program_store_fetch_en, 1);
    wb(1'b0, 4'hc, 32'h0, r);
    chk("unmapped", r, 0);
    wb(1'b1, 4'h0, 32'h2, r);
    wait_idle();
    chk("sec_clr", sec_nv, 0);
    wb(1'b0, 4'h8, 32'h0, r);
    chk("st_sec", r[3], 0);
    chk("st_done", r[4:0], 5'h02);
    sect = 10'($urandom);
    wb(1'b1, 4'h4, {22'h0, sect}, r);
    wb_sel_i <= 4'h1;
    wb(1'b1, 4'h4, 32'h0, r);
    wb_sel_i <= 4'hf;
    wb(1'b0, 4'h4, 32'h0, r);
    chk("sect_lanes", r, {22'h0, sect});
    wb(1'b1, 4'h0, 32'h1, r);
    wait_idle();
    for (int i = 0; i < 128; i++)
      chk("copy", flash_array_model_inst.mem[{1'b0, sect, i[6:0]}], i ^ 8'h5a);
    set_mode(1'b0, 1'b0, 1'b0, 1'b1);
    chk("leave", mode, `MODE_NORMAL);
    wb(1'b0, 4'h8, 32'h0, r);
    chk("locked", r, `ALL_ONES_32);
    stop_mode <= 1'b1;
    ext(`CMD_SECURE, 17'h0, 8'h1, e, q);
    wait_idle();
    chk("stop_sec", sec_nv, 1);
    ext(`CMD_SECURE, 17'h0, 8'h0, e, q);
    chk("ser_clr_err", e, 0);
    chk("ser_clr", sec_nv, 0);
    print_verdict();
  end
  initial begin
    #600000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
